// File: hdl/slsb_top.sv
// Paged lane 3 to 5 receive health registers behind an APB slave
//
// Behaviour
// R1 - Bit 7: disparity count at or above threshold
// R2 - Bit 6: not-in-table count reaches threshold
// R3 - Bit 5: unexpected control count reaches threshold
// R4 - Bit 4: inter-lane deskew achieved
// R5 - Bit 3: initial lane alignment achieved
// R6 - Bit 2: configuration checksum matches
// R7 - Bit 1: frame synchronization holds
// R8 - Bit 0: code group synchronization holds
// R9 - Status fields follow link page selector
// R10 - Lanes 4 and 5 at 0x4B4/0x4B5, reset zero
// R11 - Lane 3 at 0x4B3, same layout
// R12 - Per-lane counters compared with 8-bit threshold
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "slsb_map.svh"

module slsb_top
   import slsb_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver events, slot = link * 3 + (lane - 3)
   input wire logic [5:0] disp_err_pulse,
   input wire logic [5:0] bad_symbol_pulse,
   input wire logic [5:0] stray_control_pulse,
   // Receiver states, same slot order
   input wire logic [5:0] deskew_ok_in,
   input wire logic [5:0] init_align_ok_in,
   input wire logic [5:0] checksum_ok_in,
   input wire logic [5:0] frame_sync_ok_in,
   input wire logic [5:0] codegroup_sync_ok_in,
   // Interrupt
   output logic irq
);

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic link_page_reg;
   slsb_byte_t threshold_reg;
   slsb_irq_t irq_status_reg;
   slsb_irq_t irq_mask_reg;
   slsb_irq_t irq_status_next;
   slsb_irq_t irq_events;
   slsb_word_t prdata_reg;
   slsb_word_t prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   slsb_idx_t reg_idx;
   logic aligned;
   logic setup_phase;
   logic write_strobe;
   logic wr_page;
   logic wr_threshold;
   logic wr_count_clr;
   logic wr_irq_stat;
   logic wr_irq_mask;
   logic [5:0] clear_slot;
   logic [5:0] err_rise;
   logic [5:0] sync_drop;
   slsb_byte_t health [0:5];
   slsb_byte_t lane3_rx_health;
   slsb_byte_t lane4_rx_health;
   slsb_byte_t lane5_rx_health;

   // ----------------------------------------------------------------------------
   // Address decode helpers
   // ----------------------------------------------------------------------------
   assign reg_idx = paddr[13:2];
   assign aligned = paddr[1:0] == 2'h0;
   assign setup_phase = psel && !penable;
   assign write_strobe = psel && penable && pwrite;

   // Zero wait states: read data is caught in the setup cycle
   assign pready = psel && penable;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   always_comb begin
      wr_page = 1'b0;
      wr_threshold = 1'b0;
      wr_count_clr = 1'b0;
      wr_irq_stat = 1'b0;
      wr_irq_mask = 1'b0;
      if (!write_strobe || !aligned) begin
         wr_page = 1'b0;
      end else if (reg_idx == `SLSB_IDX_LINK_PAGE) begin
         wr_page = 1'b1;
      end else if (reg_idx == `SLSB_IDX_THRESHOLD) begin
         wr_threshold = 1'b1;
      end else if (reg_idx == `SLSB_IDX_COUNT_CLR) begin
         wr_count_clr = 1'b1;
      end else if (reg_idx == `SLSB_IDX_IRQ_STAT) begin
         wr_irq_stat = 1'b1;
      end else if (reg_idx == `SLSB_IDX_IRQ_MASK) begin
         wr_irq_mask = 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_page_reg <= `SLSB_RST_PAGE;
      end else if (wr_page) begin
         link_page_reg <= pwdata[`SLSB_BIT_PAGE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         threshold_reg <= `SLSB_RST_THRESHOLD;
      end else if (wr_threshold) begin
         threshold_reg <= pwdata[7:0];
      end
   end

   // Clearing acts on the counters of the link currently paged in
   always_comb begin
      clear_slot = 6'h00;
      if (wr_count_clr && pwdata[`SLSB_BIT_CLR_PAGED]) begin
         clear_slot = link_page_reg ? 6'h38 : 6'h07;
      end
   end

   // ----------------------------------------------------------------------------
   // Lane status slots, three lanes for each of two links
   // ----------------------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < `SLSB_SLOTS; s = s + 1) begin : g_slot
         slsb_lane_health u_lane (
            .pclk(pclk),
            .presetn(presetn),
            .disp_err_pulse(disp_err_pulse[s]),
            .bad_symbol_pulse(bad_symbol_pulse[s]),
            .stray_control_pulse(stray_control_pulse[s]),
            .deskew_ok_in(deskew_ok_in[s]),
            .init_align_ok_in(init_align_ok_in[s]),
            .checksum_ok_in(checksum_ok_in[s]),
            .frame_sync_ok_in(frame_sync_ok_in[s]),
            .codegroup_sync_ok_in(codegroup_sync_ok_in[s]),
            .error_threshold(threshold_reg),
            .clear_counts(clear_slot[s]),
            .health_reg(health[s]),
            .err_rise(err_rise[s]),
            .sync_drop(sync_drop[s])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Page selection of the visible status bytes
   // ----------------------------------------------------------------------------
   assign lane3_rx_health = link_page_reg ? health[3] : health[0]; // R9
   assign lane4_rx_health = link_page_reg ? health[4] : health[1]; // R9
   assign lane5_rx_health = link_page_reg ? health[5] : health[2]; // R9

   // ----------------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------------
   assign irq_events = {sync_drop, err_rise};

   // A new event wins over a write-one-to-clear in the same cycle
   always_comb begin
      irq_status_next = irq_status_reg;
      if (wr_irq_stat) begin
         irq_status_next = irq_status_next & ~pwdata[11:0];
      end
      irq_status_next = irq_status_next | irq_events;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= `SLSB_RST_IRQ;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= `SLSB_RST_IRQ;
      end else if (wr_irq_mask) begin
         irq_mask_reg <= pwdata[11:0];
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // ----------------------------------------------------------------------------
   // Read data and error response
   // ----------------------------------------------------------------------------
   always_comb begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (!aligned) begin
         pslverr_next = 1'b1;
      end else if (reg_idx == `SLSB_IDX_LINK_PAGE) begin
         prdata_next = {31'h0000_0000, link_page_reg};
      end else if (reg_idx == `SLSB_IDX_THRESHOLD) begin
         prdata_next = {24'h00_0000, threshold_reg};
      end else if (reg_idx == `SLSB_IDX_COUNT_CLR) begin
         prdata_next = 32'h0000_0000;
      end else if (reg_idx == `SLSB_IDX_IRQ_STAT) begin
         prdata_next = {20'h0_0000, irq_status_reg};
      end else if (reg_idx == `SLSB_IDX_IRQ_MASK) begin
         prdata_next = {20'h0_0000, irq_mask_reg};
      end else if (reg_idx == `SLSB_IDX_LANE3) begin
         prdata_next = {24'h00_0000, lane3_rx_health}; // R11
      end else if (reg_idx == `SLSB_IDX_LANE4) begin
         prdata_next = {24'h00_0000, lane4_rx_health}; // R10
      end else if (reg_idx == `SLSB_IDX_LANE5) begin
         prdata_next = {24'h00_0000, lane5_rx_health}; // R10
      end else begin
         pslverr_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup_phase) begin
         prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

endmodule

// File: hdl/slsb_map.svh
// Register indices, field positions, reset values and widths of the lane status bank
`ifndef SLSB_MAP_SVH
`define SLSB_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SLSB_IDX_LINK_PAGE 12'h300
`define SLSB_IDX_THRESHOLD 12'h301
`define SLSB_IDX_COUNT_CLR 12'h302
`define SLSB_IDX_IRQ_STAT 12'h303
`define SLSB_IDX_IRQ_MASK 12'h304
`define SLSB_IDX_LANE3 12'h4B3
`define SLSB_IDX_LANE4 12'h4B4
`define SLSB_IDX_LANE5 12'h4B5

// ----------------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------------
`define SLSB_BIT_DISPARITY 7
`define SLSB_BIT_BAD_SYMBOL 6
`define SLSB_BIT_STRAY_CTRL 5
`define SLSB_BIT_DESKEW 4
`define SLSB_BIT_INIT_ALIGN 3
`define SLSB_BIT_CHECKSUM 2
`define SLSB_BIT_FRAME_SYNC 1
`define SLSB_BIT_CG_SYNC 0

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define SLSB_BIT_PAGE 0
`define SLSB_BIT_CLR_PAGED 0
`define SLSB_IRQ_SYNC_BASE 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SLSB_RST_STATUS 8'h00
`define SLSB_RST_THRESHOLD 8'hFF
`define SLSB_RST_PAGE 1'h0
`define SLSB_RST_IRQ 12'h000
`define SLSB_RST_COUNT 8'h00
`define SLSB_COUNT_MAX 8'hFF

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define SLSB_LANES_PER_LINK 3
`define SLSB_SLOTS 6
`define SLSB_IRQ_BITS 12

`endif

// File: hdl/slsb_pkg.sv
// Types shared by the lane status bank
package slsb_pkg;
   typedef logic [7:0] slsb_byte_t;
   typedef logic [11:0] slsb_idx_t;
   typedef logic [31:0] slsb_word_t;
   typedef logic [11:0] slsb_irq_t;
endpackage

// File: hdl/slsb_lane_health.sv
// One lane of one link: error counters, threshold compare and status byte
`timescale 1ns/100ps
`include "slsb_map.svh"

module slsb_lane_health
   import slsb_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Receiver events and states
   input wire logic disp_err_pulse,
   input wire logic bad_symbol_pulse,
   input wire logic stray_control_pulse,
   input wire logic deskew_ok_in,
   input wire logic init_align_ok_in,
   input wire logic checksum_ok_in,
   input wire logic frame_sync_ok_in,
   input wire logic codegroup_sync_ok_in,
   // Control
   input wire slsb_byte_t error_threshold,
   input wire logic clear_counts,
   // Results
   output slsb_byte_t health_reg,
   output logic err_rise,
   output logic sync_drop
);

   slsb_byte_t disp_count_reg;
   slsb_byte_t bad_count_reg;
   slsb_byte_t stray_count_reg;
   slsb_byte_t health_next;

   // ----------------------------------------------------------------------------
   // Saturating counters; an event in the clear cycle counts as the first
   // ----------------------------------------------------------------------------
   function automatic slsb_byte_t count_step(input slsb_byte_t cnt, input logic ev, input logic clr);
      slsb_byte_t res;
      res = cnt;
      if (clr) begin
         res = ev ? 8'h01 : `SLSB_RST_COUNT;
      end else if (ev && cnt != `SLSB_COUNT_MAX) begin
         res = cnt + 8'h01;
      end
      return res;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_count_reg <= `SLSB_RST_COUNT;
         bad_count_reg <= `SLSB_RST_COUNT;
         stray_count_reg <= `SLSB_RST_COUNT;
      end else begin
         disp_count_reg <= count_step(disp_count_reg, disp_err_pulse, clear_counts); // R12
         bad_count_reg <= count_step(bad_count_reg, bad_symbol_pulse, clear_counts); // R12
         stray_count_reg <= count_step(stray_count_reg, stray_control_pulse, clear_counts); // R12
      end
   end

   // ----------------------------------------------------------------------------
   // Status byte
   // ----------------------------------------------------------------------------
   always_comb begin
      health_next = `SLSB_RST_STATUS;
      health_next[`SLSB_BIT_DISPARITY] = disp_count_reg >= error_threshold; // R1
      health_next[`SLSB_BIT_BAD_SYMBOL] = bad_count_reg >= error_threshold; // R2
      health_next[`SLSB_BIT_STRAY_CTRL] = stray_count_reg >= error_threshold; // R3
      health_next[`SLSB_BIT_DESKEW] = deskew_ok_in; // R4
      health_next[`SLSB_BIT_INIT_ALIGN] = init_align_ok_in; // R5
      health_next[`SLSB_BIT_CHECKSUM] = checksum_ok_in; // R6
      health_next[`SLSB_BIT_FRAME_SYNC] = frame_sync_ok_in; // R7
      health_next[`SLSB_BIT_CG_SYNC] = codegroup_sync_ok_in; // R8
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         health_reg <= `SLSB_RST_STATUS;
      end else begin
         health_reg <= health_next;
      end
   end

   // Interrupt events: an error flag turning on, or frame or code group sync lost
   assign err_rise = |(health_next[7:5] & ~health_reg[7:5]);
   assign sync_drop = |(health_reg[1:0] & ~health_next[1:0]);

endmodule

// File: sim/slsb_top_asserts.sv
// Port-level checks of the lane status bank
`timescale 1ns/100ps
module slsb_top_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupt
   input wire logic irq
);
   // ----
   // Mask shadow
   // ----
   logic [11:0] mask_reg;
   wire setup = psel && !penable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= 12'h000;
      end else if (psel && penable && pwrite && paddr == 14'h0C10) begin
         mask_reg <= pwdata[11:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready in access");
   property p_unal; setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0; endproperty
   a_unal: assert property (p_unal) else $error("unaligned not refused");
   property p_stand; !setup |=> $stable(prdata) && $stable(pslverr); endproperty
   a_stand: assert property (p_stand) else $error("read data moved");
   property p_wrzero; setup && pwrite |=> prdata == 32'h0; endproperty
   a_wrzero: assert property (p_wrzero) else $error("data on write");
   property p_lanes;
      setup && !pwrite && paddr inside {14'h12CC, 14'h12D0, 14'h12D4} |=> !pslverr && prdata[31:8] == 24'h0;
   endproperty
   a_lanes: assert property (p_lanes) else $error("status read bad");
   property p_hole; setup && paddr == 14'h12D8 |=> pslverr && prdata == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("hole not refused");
   property p_clr; setup && !pwrite && paddr == 14'h0C08 |=> prdata == 32'h0 ##1 prdata == 32'h0; endproperty
   a_clr: assert property (p_clr) else $error("clear reads nonzero");
   property p_page; setup && !pwrite && paddr == 14'h0C00 |=> prdata[31:1] == 31'h0 && !pslverr; endproperty
   a_page: assert property (p_page) else $error("page read bad");
   property p_mask; mask_reg == 12'h000 |-> !irq; endproperty
   a_mask: assert property (p_mask) else $error("irq while masked");
   c_wr: cover property (setup && pwrite);
   c_irq: cover property ($rose(irq));
   c_l4: cover property (setup && paddr == 14'h12D0);
endmodule

// File: sim/slsb_far_end.sv
// Far-end transmitter model: bursts of error symbols
`timescale 1ns/100ps
module slsb_far_end (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [5:0] slot,
   input wire logic [7:0] count,
   input wire logic [3:0] gap,
   output logic busy,
   // Error events
   output logic [5:0] disp_err_pulse,
   output logic [5:0] bad_symbol_pulse,
   output logic [5:0] stray_control_pulse
);
   logic [7:0] left_reg;
   logic [3:0] wait_reg;
   logic fire;
   assign busy = left_reg != 8'h00;
   assign fire = busy && wait_reg == 4'h0;
   assign disp_err_pulse = (fire && kind[0]) ? slot : 6'h00;
   assign bad_symbol_pulse = (fire && kind[1]) ? slot : 6'h00;
   assign stray_control_pulse = (fire && kind[2]) ? slot : 6'h00;
   // Gap sets prompt or slow symbol spacing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_reg <= 8'h00;
         wait_reg <= 4'h0;
      end else if (go) begin
         left_reg <= count;
         wait_reg <= 4'h0;
      end else if (fire) begin
         left_reg <= left_reg - 8'h01;
         wait_reg <= gap;
      end else if (busy) begin
         wait_reg <= wait_reg - 4'h1;
      end
   end
endmodule

// File: sim/slsb_top_tb.sv
// Self-checking bench of the lane status bank
`timescale 1ns/100ps
`include "slsb_map.svh"
module slsb_top_tb;
   localparam logic [13:0] a_pg = {`SLSB_IDX_LINK_PAGE, 2'h0};
   localparam logic [13:0] a_th = {`SLSB_IDX_THRESHOLD, 2'h0};
   localparam logic [13:0] a_cl = {`SLSB_IDX_COUNT_CLR, 2'h0};
   localparam logic [13:0] a_is = {`SLSB_IDX_IRQ_STAT, 2'h0};
   localparam logic [13:0] a_im = {`SLSB_IDX_IRQ_MASK, 2'h0};
   localparam logic [13:0] a_l3 = {`SLSB_IDX_LANE3, 2'h0};
   localparam logic [13:0] a_l4 = {`SLSB_IDX_LANE4, 2'h0};
   localparam logic [13:0] a_l5 = {`SLSB_IDX_LANE5, 2'h0};
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
   logic [13:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, r, prdata;
   logic pready, pslverr, irq, busy, er;
   logic [2:0] kind = 0;
   logic [5:0] slot = 0, dk = 0, ia = 0, ck = 0, fs = 0, cg = 0, dpe, bse, sce;
   logic [7:0] count = 0;
   logic [3:0] gap = 0;
   int err_total = 0, checked = 0, cyc = 0, seed = 97472;
   always #5 pclk = ~pclk;
   slsb_top slsb_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .disp_err_pulse(dpe), .bad_symbol_pulse(bse), .stray_control_pulse(sce), .deskew_ok_in(dk),
      .init_align_ok_in(ia), .checksum_ok_in(ck), .frame_sync_ok_in(fs), .codegroup_sync_ok_in(cg), .irq);
   slsb_far_end slsb_far_end_inst (.pclk, .presetn, .go, .kind, .slot, .count, .gap, .busy,
      .disp_err_pulse(dpe), .bad_symbol_pulse(bse), .stray_control_pulse(sce));
   // ----
   // Tasks
   // ----
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdl(input logic [13:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk({er, rd}, {1'b0, e});
   endtask
   task automatic burst(input logic [2:0] k, input logic [5:0] s, input logic [7:0] n);
      @(posedge pclk);
      kind <= k;
      slot <= s;
      count <= n;
      gap <= 4'($random(seed));
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      while (busy) @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask
   function automatic logic [31:0] st_exp(input int s, input logic [2:0] fl);
      return {24'h0, fl, dk[s], ia[s], ck[s], fs[s], cg[s]};
   endfunction
   // ----
   // Sequence
   // ----
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdl(a_l3, 32'h0);
      rdl(a_l4, 32'h0);
      rdl(a_l5, 32'h0);
      rdl(a_th, 32'hFF);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         r = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         @(posedge pclk);
         {dk, ia, ck, fs, cg} <= r[29:0];
         for (int p = 0; p < 2; p++) begin
            apb(1'b1, a_pg, 32'(p));
            for (int l = 0; l < 3; l++) rdl(a_l3 + 14'(4 * l), st_exp(p * 3 + l, 3'h0));
         end
      end
      $display("test states done");
      apb(1'b1, a_pg, 32'h0);
      apb(1'b1, a_th, 32'h3);
      rdl(a_th, 32'h3);
      apb(1'b1, a_is, 32'hFFF);
      for (int k = 0; k < 3; k++) begin
         burst(3'(1 << k), 6'h02, 8'h02);
         rdl(a_l4, st_exp(1, 3'h0));
         burst(3'(1 << k), 6'h02, 8'h01);
         rdl(a_l4, st_exp(1, 3'(4 >> k)));
         apb(1'b1, a_cl, 32'h1);
         rdl(a_l4, st_exp(1, 3'h0));
      end
      burst(3'h1, 6'h10, 8'h03);
      rdl(a_l4, st_exp(1, 3'h0));
      apb(1'b1, a_pg, 32'h1);
      rdl(a_l4, st_exp(4, 3'h4));
      $display("test errors done");
      rdl(a_is, 32'h012);
      chk({32'h0, irq}, 33'h0);
      apb(1'b1, a_im, 32'h010);
      @(posedge pclk);
      chk({32'h0, irq}, 33'h1);
      apb(1'b1, a_is, 32'h010);
      @(posedge pclk);
      chk({32'h0, irq}, 33'h0);
      rdl(a_is, 32'h002);
      @(posedge pclk);
      {fs, cg} <= 12'hFFF;
      repeat (3) @(posedge pclk);
      apb(1'b1, a_is, 32'hFFF);
      {fs, cg} <= {6'h2F, 6'h3E};
      repeat (3) @(posedge pclk);
      rdl(a_is, 32'h440);
      rdl(a_l4, st_exp(4, 3'h4));
      $display("test irq done");
      apb(1'b1, a_l4, 32'hFF);
      rdl(a_l4, st_exp(4, 3'h4));
      apb(1'b0, a_l4 + 14'h1, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      apb(1'b0, a_l5 + 14'h4, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      apb(1'b1, a_cl, 32'h1);
      rdl(a_l4, st_exp(4, 3'h0));
      apb(1'b1, a_th, 32'hFF);
      burst(3'h2, 6'h10, 8'hFF);
      burst(3'h2, 6'h10, 8'h02);
      rdl(a_l4, st_exp(4, 3'h2));
      apb(1'b1, a_th, 32'h0);
      repeat (2) @(posedge pclk);
      rdl(a_l5, st_exp(5, 3'h7));
      $display("test refusals done");
      report_and_stop;
   end
endmodule
bind slsb_top slsb_top_asserts slsb_top_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .irq);
